// file: rtl/clpr_pkg.sv
// How it works
// R1: ready flag set on new ppm result
// R2: inhibit clear: power down 100 ms after loss
// R3: inhibit set: power up at first detect, stay
// R4: lock criteria checked continuously after lock
// R5: failed check repeated count times, then unlock
// R6: lock regained: keep lock, zero recheck counter
// R7: step limit caps taps 2 to 5 change
// R8: same step limit for both polarities
// R9: scale 00 unchanged, 01 adds window[3:1]
// R10: scale 10 doubles, 11 doubles plus window[3:1]
// R11: trigger captures counter, self clears when done
// R12: result otherwise updates continuously
// R13: first tap magnitude bounded by limit
package clpr_pkg;
   // -----------------------------------------
   // Register offsets.
   // -----------------------------------------
   localparam logic [7:0] OFS_LOCK_POWER = 8'h34; // Control and ready flag.
   localparam logic [7:0] OFS_PPM_TAP = 8'h35; // Tolerance, trigger, tap 1 limit.
   localparam logic [7:0] OFS_RESULT_HI = 8'h3B; // Result high byte.
   localparam logic [7:0] OFS_RESULT_LO = 8'h3C; // Result low byte.
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h40; // Sticky events.
   localparam logic [7:0] OFS_IRQ_MASK = 8'h41; // Event mask.
   // -----------------------------------------
   // Field positions and reset values.
   // -----------------------------------------
   localparam int BIT_RDY = 7; // Ppm result ready.
   localparam int BIT_INHIBIT = 6; // Idle power-down inhibit.
   localparam int BIT_RECHK = 4; // Recheck count, two bits.
   localparam int BIT_SCALE = 6; // Tolerance scale, two bits.
   localparam int BIT_TRIG = 5; // Manual measure trigger.
   localparam logic [7:0] RST_LOCK_POWER = 8'h3F; // Reset of 0x34.
   localparam logic [7:0] RST_PPM_TAP = 8'h0F; // Reset of 0x35.
   // -----------------------------------------
   // Timing.
   // -----------------------------------------
   localparam int CLK_MHZ = 125; // System clock rate.
   localparam int IDLE_MS = 100; // Power-down delay.
   localparam int IDLE_CYC = IDLE_MS * 1000 * CLK_MHZ; // Cycles in delay.
   localparam int TICK_CYC = 4096; // Lock check spacing.
   // Lock monitor states.
   typedef enum logic [1:0] {LK_ACQ, LK_LOCKED, LK_RECHECK} clpr_lock_t;
endpackage

// file: rtl/clpr_tap_limit.sv
`timescale 1ns/1ns
// Clamps one signed tap step and the resulting tap, registered.
module clpr_tap_limit (
   input wire logic clk, // System clock.
   input wire logic rst, // Synchronous reset.
   input wire logic en, // Apply step.
   input wire logic signed [7:0] step, // Requested change.
   input wire logic [4:0] step_lim, // Step limit.
   input wire logic [4:0] mag_lim, // Magnitude limit.
   output logic signed [7:0] tap // Tap value.
);
   logic signed [7:0] tap_r; // Stored tap.
   logic signed [7:0] tap_nxt; // Next tap.
   logic signed [8:0] s; // Clamped step.
   logic signed [8:0] v; // Sum before clamp.
   // Clamp step both ways, add, clamp magnitude.
   always_comb begin
      s = 9'(step);
      if (s > $signed({4'h0, step_lim})) begin // see R7
         s = $signed({4'h0, step_lim});
      end else if (s < -$signed({4'h0, step_lim})) begin // see R8
         s = -$signed({4'h0, step_lim});
      end
      v = 9'(tap_r) + s;
      if (v > $signed({4'h0, mag_lim})) begin // see R13
         v = $signed({4'h0, mag_lim});
      end else if (v < -$signed({4'h0, mag_lim})) begin
         v = -$signed({4'h0, mag_lim});
      end
      tap_nxt = en ? v[7:0] : tap_r;
   end
   // Register the tap.
   always_ff @(posedge clk) begin
      tap_r <= rst ? 8'h00 : tap_nxt;
   end
   assign tap = tap_r;
endmodule

// file: rtl/clpr_regs.sv
// Chosen here: strobed register access.
`timescale 1ns/1ns
// -----------------------------------------
// Channel lock, power and equalizer limits.
// -----------------------------------------
module clpr_regs #(
   parameter int IDLE_CYCLES = clpr_pkg::IDLE_CYC, // Power-down delay.
   parameter int TICK_CYCLES = clpr_pkg::TICK_CYC // Lock check spacing.
) (
   input wire logic clk, // System clock.
   input wire logic rst, // Synchronous reset.
   input wire logic [7:0] addr, // Register address.
   input wire logic [7:0] wdata, // Write data.
   input wire logic wr, // Write strobe.
   input wire logic rd, // Read strobe.
   output logic [7:0] rdata, // Read data, cycle after rd.
   input wire logic sig_det, // Signal detect.
   input wire logic lock_ok, // Lock criteria met.
   input wire logic [15:0] ppm_count, // Frequency offset counter.
   input wire logic [7:0] ppm_window, // Tolerance window.
   input wire logic adapt_en, // Adaptation step strobe.
   input wire logic signed [7:0] tap_step [5], // Requested steps, taps 1..5.
   output logic [8:0] ppm_tol, // Scaled tolerance.
   output logic chan_power, // Channel blocks powered.
   output logic locked, // Lock indication.
   output logic signed [7:0] tap [5], // Tap values, taps 1..5.
   output logic irq // Interrupt, level.
);
   // -----------------------------------------
   // Register state.
   // -----------------------------------------
   logic [7:0] ctl_r, ctl_nxt; // 0x34 writable bits plus ready.
   logic [7:0] tap_r, tap_nxt; // 0x35.
   logic [15:0] res_r, res_nxt; // Captured result.
   logic [7:0] rdata_r, rdata_nxt; // Read data.
   logic [2:0] sts_r, sts_nxt; // Sticky: ready, lock loss, power down.
   logic [2:0] msk_r, msk_nxt; // Mask.
   logic [31:0] idle_r, idle_nxt; // Idle counter.
   logic pwr_r, pwr_nxt; // Power state.
   logic seen_r, seen_nxt; // Detect seen since reset.
   logic [31:0] tick_r, tick_nxt; // Check divider.
   logic [1:0] rchk_r, rchk_nxt; // Recheck counter.
   clpr_pkg::clpr_lock_t st_r, st_nxt; // Lock monitor state.
   logic tick; // One-cycle check enable.
   logic [2:0] ev; // Events this cycle.
   logic rd_sts; // Status read.

   assign tick = (tick_r == 32'(TICK_CYCLES - 1));
   assign rd_sts = rd && addr == clpr_pkg::OFS_IRQ_STATUS;

   // Register file, result capture and read mux.
   always_comb begin
      ctl_nxt = ctl_r;
      tap_nxt = tap_r;
      res_nxt = res_r;
      msk_nxt = msk_r;
      rdata_nxt = 8'h00;
      if (wr && addr == clpr_pkg::OFS_LOCK_POWER) begin
         ctl_nxt[6:0] = wdata[6:0];
      end
      if (wr && addr == clpr_pkg::OFS_PPM_TAP) begin
         tap_nxt = wdata;
      end
      if (wr && addr == clpr_pkg::OFS_IRQ_MASK) begin
         msk_nxt = wdata[2:0];
      end
      if (tap_r[clpr_pkg::BIT_TRIG]) begin
         res_nxt = ppm_count; // see R11
         tap_nxt[clpr_pkg::BIT_TRIG] = 1'b0; // see R11
      end else if (tick) begin
         res_nxt = ppm_count; // see R12
      end
      if (tap_r[clpr_pkg::BIT_TRIG] || tick) begin
         ctl_nxt[clpr_pkg::BIT_RDY] = 1'b1; // see R1
      end else if (rd && addr == clpr_pkg::OFS_RESULT_LO) begin
         ctl_nxt[clpr_pkg::BIT_RDY] = 1'b0;
      end
      if (rd) begin
         unique case (addr)
            clpr_pkg::OFS_LOCK_POWER: rdata_nxt = ctl_r;
            clpr_pkg::OFS_PPM_TAP: rdata_nxt = tap_r;
            clpr_pkg::OFS_RESULT_HI: rdata_nxt = res_r[15:8];
            clpr_pkg::OFS_RESULT_LO: rdata_nxt = res_r[7:0];
            clpr_pkg::OFS_IRQ_STATUS: rdata_nxt = {5'h00, sts_r};
            clpr_pkg::OFS_IRQ_MASK: rdata_nxt = {5'h00, msk_r};
            default: rdata_nxt = 8'h00;
         endcase
      end
   end

   // Power policy after signal detect.
   always_comb begin
      idle_nxt = idle_r;
      pwr_nxt = pwr_r;
      seen_nxt = seen_r | sig_det;
      if (ctl_r[clpr_pkg::BIT_INHIBIT]) begin
         idle_nxt = 32'h0;
         if (sig_det || seen_r) begin
            pwr_nxt = 1'b1; // see R3
         end
      end else if (sig_det) begin
         idle_nxt = 32'h0;
         pwr_nxt = 1'b1;
      end else if (pwr_r) begin
         if (idle_r == 32'(IDLE_CYCLES - 1)) begin
            pwr_nxt = 1'b0; // see R2
         end else begin
            idle_nxt = idle_r + 32'h1;
         end
      end
   end

   // Lock monitor with recheck counter.
   always_comb begin
      st_nxt = st_r;
      rchk_nxt = rchk_r;
      tick_nxt = tick ? 32'h0 : tick_r + 32'h1;
      if (tick) begin
         unique case (st_r)
            clpr_pkg::LK_ACQ: begin
               if (lock_ok) begin
                  st_nxt = clpr_pkg::LK_LOCKED;
               end
            end
            clpr_pkg::LK_LOCKED: begin
               if (!lock_ok) begin // see R4
                  if (ctl_r[5:4] == 2'h0) begin
                     st_nxt = clpr_pkg::LK_ACQ;
                  end else begin
                     st_nxt = clpr_pkg::LK_RECHECK;
                     rchk_nxt = 2'h1;
                  end
               end
            end
            clpr_pkg::LK_RECHECK: begin
               if (lock_ok) begin
                  st_nxt = clpr_pkg::LK_LOCKED; // see R6
                  rchk_nxt = 2'h0; // see R6
               end else if (rchk_r >= ctl_r[5:4]) begin
                  st_nxt = clpr_pkg::LK_ACQ; // see R5
                  rchk_nxt = 2'h0;
               end else begin
                  rchk_nxt = rchk_r + 2'h1; // see R5
               end
            end
         endcase
      end
   end

   // Sticky status; a read clears, a new event wins.
   always_comb begin
      ev[0] = tap_r[clpr_pkg::BIT_TRIG] || tick;
      ev[1] = tick && st_nxt == clpr_pkg::LK_ACQ && st_r != clpr_pkg::LK_ACQ;
      ev[2] = pwr_r && !pwr_nxt;
      sts_nxt = (rd_sts ? 3'h0 : sts_r) | ev;
   end

   // Register every group.
   always_ff @(posedge clk) begin
      if (rst) begin
         ctl_r <= clpr_pkg::RST_LOCK_POWER;
         tap_r <= clpr_pkg::RST_PPM_TAP;
         res_r <= 16'h0000;
         rdata_r <= 8'h00;
         sts_r <= 3'h0;
         msk_r <= 3'h0;
         idle_r <= 32'h0;
         pwr_r <= 1'b0;
         seen_r <= 1'b0;
         tick_r <= 32'h0;
         rchk_r <= 2'h0;
         st_r <= clpr_pkg::LK_ACQ;
      end else begin
         ctl_r <= ctl_nxt;
         tap_r <= tap_nxt;
         res_r <= res_nxt;
         rdata_r <= rdata_nxt;
         sts_r <= sts_nxt;
         msk_r <= msk_nxt;
         idle_r <= idle_nxt;
         pwr_r <= pwr_nxt;
         seen_r <= seen_nxt;
         tick_r <= tick_nxt;
         rchk_r <= rchk_nxt;
         st_r <= st_nxt;
      end
   end

   // Tolerance scaling.
   always_comb begin
      unique case (tap_r[7:6])
         2'h0: ppm_tol = {1'b0, ppm_window}; // see R9
         2'h1: ppm_tol = {1'b0, ppm_window} + {6'h00, ppm_window[3:1]}; // see R9
         2'h2: ppm_tol = {ppm_window, 1'b0}; // see R10
         2'h3: ppm_tol = {ppm_window, 1'b0} + {6'h00, ppm_window[3:1]}; // see R10
      endcase
   end

   // Equalizer taps: tap 1 magnitude, taps 2..5 step limited.
   for (genvar i = 0; i < 5; i++) begin : g_tap
      clpr_tap_limit u_lim (
         .clk(clk),
         .rst(rst),
         .en(adapt_en),
         .step(tap_step[i]),
         .step_lim(i == 0 ? 5'h1F : {1'b0, ctl_r[3:0]}), // see R7
         .mag_lim(i == 0 ? tap_r[4:0] : 5'h1F), // see R13
         .tap(tap[i])
      );
   end

   assign rdata = rdata_r;
   assign chan_power = pwr_r;
   assign locked = st_r != clpr_pkg::LK_ACQ;
   assign irq = |(sts_r & msk_r);

   // -----------------------------------------
   // Checks.
   // -----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_trig_self_clear: assert property (tap_r[5] |=> !tap_r[5] && ctl_r[7]) // see R11
      else $error("trigger did not clear or flag ready");
   a_ready_on_result: assert property (tick |=> ctl_r[7]) // see R1
      else $error("ready flag not set");
   a_power_down_idle: assert property (!ctl_r[6] && !sig_det && pwr_r
      && idle_r == 32'(IDLE_CYCLES - 1) |=> !pwr_r) // see R2
      else $error("no power down after idle");
   a_inhibit_keeps_on: assert property (ctl_r[6] && pwr_r |=> pwr_r) // see R3
      else $error("power dropped with inhibit");
   a_regain_keeps_lock: assert property (st_r == clpr_pkg::LK_RECHECK && tick
      && lock_ok |=> locked && rchk_r == 2'h0) // see R6
      else $error("regain lost lock");
   a_recheck_bounded: assert property (rchk_r <= ctl_r[5:4] || !locked) // see R5
      else $error("recheck over count");
   a_monitor_locked: assert property (st_r == clpr_pkg::LK_LOCKED && tick
      && !lock_ok |=> st_r != clpr_pkg::LK_LOCKED) // see R4
      else $error("failed check ignored");
   a_scale_double: assert property (tap_r[7:6] == 2'h2 |-> ppm_tol
      == 9'(ppm_window) * 9'h2) // see R10
      else $error("scale wrong");
   a_scale_unity: assert property (tap_r[7:6] == 2'h0 |-> ppm_tol == 9'(ppm_window)) // see R9
      else $error("scale changed");
   // A manual trigger captures the counter value present while it is pending.
   a_trig_capture: assert property (tap_r[5] |=> res_r == $past(ppm_count)) // see R11
      else $error("trigger did not capture count");
   // Each check tick refreshes the result without any trigger.
   a_result_tick: assert property (tick |=> res_r == $past(ppm_count)) // see R12
      else $error("result not refreshed on tick");
   // Read data are zero in every cycle that does not follow a read.
   a_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside answer cycle");
   // The lock loss status bit stays until its register is read.
   a_status_sticky: assert property (sts_r[1] && !rd_sts |=> sts_r[1])
      else $error("lock loss status dropped");
   // Tap 1 never leaves the magnitude bound that was set when it adapted.
   a_first_tap_bound: assert property (adapt_en |=> tap[0]
      <= $signed({4'h0, $past(tap_r[4:0])}) && tap[0]
      >= -$signed({4'h0, $past(tap_r[4:0])})) // see R13
      else $error("tap 1 over magnitude");

   // -----------------------------------------
   // Late tap step checks, one per tap.
   // -----------------------------------------
   // Every late tap moves by at most the step limit, up or down alike.
   for (genvar j = 1; j < 5; j++) begin : g_step_chk
      a_late_step_limit: assert property (adapt_en |=> 9'(tap[j]) - 9'($past(tap[j]))
         <= $signed({5'h00, $past(ctl_r[3:0])}) && 9'($past(tap[j])) - 9'(tap[j])
         <= $signed({5'h00, $past(ctl_r[3:0])})) // see R7 R8
         else $error("late tap step over limit");
   end

   // -----------------------------------------
   // Scenario covers.
   // -----------------------------------------
   // A manual trigger that is taken and cleared.
   c_trigger: cover property (tap_r[5] ##1 !tap_r[5]);
   // Idle power-down after signal detect is lost.
   c_power_down: cover property (pwr_r ##1 !pwr_r);
   c_lock_loss: cover property (locked ##1 !locked);
   c_regain: cover property (st_r == clpr_pkg::LK_RECHECK ##1 st_r == clpr_pkg::LK_LOCKED);
endmodule

// file: testbench/test_cdr_lock_ppm_dfe_limit_regs.sv
`timescale 1ns/1ns
// -----------------------------------------
// Bench for the channel lock, power and limit registers.
// -----------------------------------------
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin \
   num_errors++; $display("MISMATCH t=%0t %s", $time, msg); end end
module test_cdr_lock_ppm_dfe_limit_regs;
   logic clk = 1'b0; // System clock.
   logic rst = 1'b1; // Synchronous reset.
   logic [7:0] addr = 8'h00; // Register address.
   logic [7:0] wdata = 8'h00; // Write data.
   logic wr = 1'b0; // Write strobe.
   logic rd = 1'b0; // Read strobe.
   logic [7:0] rdata; // Read data.
   logic sig_det = 1'b0; // Signal detect.
   logic lock_ok = 1'b0; // Lock criteria met.
   logic [15:0] ppm_count = 16'h0000; // Offset counter.
   logic [7:0] ppm_window = 8'hAB; // Tolerance window.
   logic adapt_en = 1'b0; // Adaptation strobe.
   logic signed [7:0] tap_step [5] = '{default: 8'sh00}; // Requested steps.
   logic [8:0] ppm_tol; // Scaled tolerance.
   logic chan_power; // Channel powered.
   logic locked; // Lock indication.
   logic signed [7:0] tap [5]; // Tap values.
   logic irq; // Interrupt.
   int num_errors = 0; // Mismatch count.
   int total_checks = 0; // Comparison count.
   logic [7:0] d; // Last read value.
   logic [8:0] tol_exp [4] = '{9'h0AB, 9'h0B0, 9'h156, 9'h15B}; // Expected scaled windows.

   // Short counts keep the power-down and lock waits brief.
   clpr_regs #(.IDLE_CYCLES(20), .TICK_CYCLES(8)) clpr_regs_inst (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .sig_det(sig_det), .lock_ok(lock_ok), .ppm_count(ppm_count),
      .ppm_window(ppm_window), .adapt_en(adapt_en), .tap_step(tap_step),
      .ppm_tol(ppm_tol), .chan_power(chan_power), .locked(locked), .tap(tap), .irq(irq));

   // The clock toggles every half period of 4 ns.
   always #4 clk = ~clk;

   // One write cycle on the register port.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // One read cycle; data are taken in the following cycle.
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Waits a number of clock edges and then lets their updates settle.
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One adaptation step with the same request on every tap.
   task automatic step_all(input logic signed [7:0] s);
      @(posedge clk);
      adapt_en <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         tap_step[i] <= s;
      end
      @(posedge clk);
      adapt_en <= 1'b0;
      wait_cyc(2);
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // The watchdog cuts a hang well past the expected few hundred cycles.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      end_sim();
   end

   // Main sequence.
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      rd_reg(8'h34);
      `CHK(d & 8'h7F, 8'h3F, "reset 0x34")
      rd_reg(8'h35);
      `CHK(d, 8'h0F, "reset 0x35")
      rd_reg(8'h50);
      `CHK(d, 8'h00, "unmapped read")
      // The ready flag is read-only and set by every tick, so the check masks it out.
      wr_reg(8'h34, 8'hFF);
      rd_reg(8'h34);
      `CHK(d & 8'h7F, 8'h7F, "write 0x34")
      // Every tolerance scale code is applied to the same window.
      for (int c = 0; c < 4; c++) begin
         wr_reg(8'h35, {c[1:0], 6'h0F});
         wait_cyc(1);
         `CHK(ppm_tol, tol_exp[c], "ppm scale")
      end
      // Late taps are step-limited both ways; tap 1 only by magnitude.
      wr_reg(8'h34, 8'h33);
      wr_reg(8'h35, 8'h05);
      step_all(8'sd10);
      `CHK(tap[0], 8'sd5, "tap1 clamp up")
      for (int i = 1; i < 5; i++) `CHK(tap[i], 8'sd3, "late step up")
      step_all(-8'sd20);
      step_all(-8'sd20);
      `CHK(tap[0], -8'sd5, "tap1 clamp down")
      for (int i = 1; i < 5; i++) `CHK(tap[i], -8'sd3, "late step down")
      // Manual capture clears itself and raises the ready flag.
      @(posedge clk);
      ppm_count <= 16'h1234;
      wr_reg(8'h35, 8'h25);
      wait_cyc(2);
      rd_reg(8'h35);
      `CHK(d & 8'h20, 8'h00, "trigger self clear")
      rd_reg(8'h34);
      `CHK(d & 8'h80, 8'h80, "ready flag")
      rd_reg(8'h3B);
      `CHK(d, 8'h12, "result high")
      rd_reg(8'h3C);
      `CHK(d, 8'h34, "result low")
      @(posedge clk);
      ppm_count <= 16'h5678;
      wait_cyc(20);
      rd_reg(8'h3B);
      `CHK(d, 8'h56, "continuous high")
      rd_reg(8'h3C);
      `CHK(d, 8'h78, "continuous low")
      // Idle power-down with the inhibit bit clear.
      wr_reg(8'h34, 8'h33);
      @(posedge clk);
      sig_det <= 1'b1;
      wait_cyc(5);
      `CHK(chan_power, 1'b1, "power on")
      @(posedge clk);
      sig_det <= 1'b0;
      wait_cyc(10);
      `CHK(chan_power, 1'b1, "power held")
      wait_cyc(20);
      `CHK(chan_power, 1'b0, "power down")
      // With the inhibit bit set the blocks stay powered.
      wr_reg(8'h34, 8'h73);
      @(posedge clk);
      sig_det <= 1'b1;
      wait_cyc(5);
      @(posedge clk);
      sig_det <= 1'b0;
      wait_cyc(40);
      `CHK(chan_power, 1'b1, "inhibit keeps power")
      // Lock loss after four failed checks, unmasked onto the interrupt.
      wr_reg(8'h41, 8'h02);
      @(posedge clk);
      lock_ok <= 1'b1;
      wait_cyc(40);
      `CHK(locked, 1'b1, "locked")
      @(posedge clk);
      lock_ok <= 1'b0;
      wait_cyc(20);
      @(posedge clk);
      lock_ok <= 1'b1;
      wait_cyc(16);
      @(posedge clk);
      lock_ok <= 1'b0;
      wait_cyc(20);
      `CHK(locked, 1'b1, "recheck restart")
      wait_cyc(30);
      `CHK(locked, 1'b0, "lock lost")
      `CHK(irq, 1'b1, "irq raised")
      rd_reg(8'h40);
      `CHK(d & 8'h02, 8'h02, "loss status")
      wait_cyc(2);
      `CHK(irq, 1'b0, "irq cleared")
      // A zero recheck count drops lock at the first failed check.
      wr_reg(8'h34, 8'h43);
      @(posedge clk);
      lock_ok <= 1'b1;
      wait_cyc(40);
      @(posedge clk);
      lock_ok <= 1'b0;
      wait_cyc(11);
      `CHK(locked, 1'b0, "no recheck")
      end_sim();
   end
endmodule
